//--- uart_rx_pkg.sv
package uart_rx_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_STAT_A = 8'h04;
  localparam logic [7:0] OFF_CTRL_B = 8'h08;
  localparam logic [7:0] OFF_CTRL_C = 8'h0C;
  localparam logic [7:0] OFF_BAUD = 8'h10;

  // status_reg_a fields
  localparam int STA_RXC = 7;
  localparam int STA_FE = 4;
  localparam int STA_DOR = 3;
  localparam int STA_PE = 2;
  localparam int STA_U2X = 1;

  // control_reg_b fields
  localparam int CTB_RECEIVE_COMPLETE_IRQ_ENABLE = 7;
  localparam int CTB_RECEIVER_ENABLE_BIT = 4;
  localparam int CTB_SIZE2 = 2;
  localparam int CTB_NINTH_RX_BIT = 1;

  // control_reg_c fields
  localparam int CTC_SYNC = 6;
  localparam int CTC_UPM1 = 5;
  localparam int CTC_UPM0 = 4;
  localparam int CTC_STOP_BITS_SELECT = 3;
  localparam int CTC_SIZE_HI = 2;
  localparam int CTC_SIZE_LO = 1;

  // Reset values
  localparam logic [7:0] CTB_RESET = 8'h00;
  localparam logic [7:0] CTC_RESET = 8'h06;
  localparam logic [11:0] BAUD_RESET = 12'h000;

  // Character size codes
  localparam logic [2:0] SIZE_9BIT = 3'h7;
  localparam logic [3:0] BITS_MIN = 4'h5;

  // Oversampling: last sample index of a bit and the first of the three voting samples
  localparam logic [3:0] SPB_NORM = 4'hF;
  localparam logic [3:0] SPB_DBL = 4'h7;
  localparam logic [3:0] VOTE1_NORM = 4'h8;
  localparam logic [3:0] VOTE1_DBL = 4'h4;

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BITS, ST_STOP} rx_state_t;

  typedef struct packed {
    logic [8:0] data;
    logic fe;
    logic overrun_flag;
    logic pe;
  } rx_entry_t;

endpackage

//--- uart_serial_receiver.sv
`timescale 1ns/1ps
// Function
// - Setting receiver enable hands the serial input pin to the receiver.
// - Synchronous mode samples bits on the external transfer clock rising edges.
// - After a valid start bit, shift bits up to first stop; ignore second stop.
// - On the first stop bit move the shift register into the receive buffer.
// - Data bits above the character size read as zero.
// - In 9-bit mode the ninth bit shows in control_reg_b, buffered per frame.
// - Reading the data location pops the FIFO and its flags.
// - Receive complete flag is one exactly while unread data is buffered.
// - Clearing receiver enable empties the buffer and clears receive complete.
// - Interrupt request follows receive complete while its enable is set.
// - Error flags travel in the buffer with their frame, shown in status_reg_a.
// - Writes to error flag positions are ignored; software writes zeros.
// - Error flags never raise an interrupt.
// - Framing error is one when the first stop bit sampled low.
// - Overrun when buffer full, shift register waiting and a new start seen.
// - Overrun clears when a frame moves from shift register into the buffer.
// - Parity check on when mode bit 1 set; compares computed and received parity.
// - Parity error reads zero when checking off, else the buffered result.
// - Clearing enable stops reception at once and frees the pin.
// - Asynchronous mode validates the start bit by majority of samples 8,9,10 or 4,5,6.
module uart_serial_receiver
  import uart_rx_pkg::*;
#(
  parameter int BAUD_W = 12
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_input_pin,
  input wire logic external_transfer_clock_pin,
  output logic pin_override,
  output logic rx_complete_irq
);

  logic [7:0] ctrl_b_r;
  logic [7:0] ctrl_c_r;
  logic u2x_r;
  logic [BAUD_W-1:0] baud_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic rx_s1_r, rx_s2_r, xck_s1_r, xck_s2_r, xck_d_r;
  logic [BAUD_W-1:0] baud_cnt_r;
  logic [3:0] smp_r;
  logic v1_r, v2_r;
  rx_state_t state_r;
  logic [3:0] idx_r;
  logic [9:0] shift_r;
  rx_entry_t mem_r [2];
  logic wr_ptr_r, rd_ptr_r;
  logic [1:0] count_r;
  rx_entry_t pend_r;
  logic pend_vld_r;
  logic dor_pend_r;

  logic receiver_enable_bit, sync_mode, upm1, upm0;
  logic [2:0] size_code;
  logic [3:0] nbits, total_bits, spb, vote1;
  logic [8:0] data_mask;
  logic tick, xck_rise, bit_evt, bit_val, maj, start_det;
  logic setup, access, wr_acc, rd_data_acc, mapped;
  logic full, pop, push;
  rx_entry_t frame_ent, push_ent, head;
  logic [31:0] rd_mux;
  logic stat_pe;

  assign receiver_enable_bit = ctrl_b_r[CTB_RECEIVER_ENABLE_BIT];
  assign sync_mode = ctrl_c_r[CTC_SYNC];
  assign upm1 = ctrl_c_r[CTC_UPM1];
  assign upm0 = ctrl_c_r[CTC_UPM0];
  assign size_code = {ctrl_b_r[CTB_SIZE2], ctrl_c_r[CTC_SIZE_HI:CTC_SIZE_LO]};
  assign nbits = (size_code == SIZE_9BIT) ? 4'h9 : (size_code[2] ? 4'h8 : BITS_MIN + {2'h0, size_code[1:0]});
  assign total_bits = nbits + {3'h0, upm1};
  assign data_mask = 9'h1FF >> (4'h9 - nbits);
  assign spb = u2x_r ? SPB_DBL : SPB_NORM;
  assign vote1 = u2x_r ? VOTE1_DBL : VOTE1_NORM;

  assign pin_override = receiver_enable_bit;
  assign rx_complete_irq = ctrl_b_r[CTB_RECEIVE_COMPLETE_IRQ_ENABLE] & (count_r != 2'h0);

  // APB: zero wait states; read data is captured in the setup cycle
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr_acc = access & pwrite;
  assign rd_data_acc = access & ~pwrite & (paddr == OFF_DATA);
  assign mapped = (paddr == OFF_DATA) | (paddr == OFF_STAT_A) | (paddr == OFF_CTRL_B) |
                  (paddr == OFF_CTRL_C) | (paddr == OFF_BAUD);
  assign pready = access;
  assign pslverr = pslverr_r & access;
  assign prdata = prdata_r;

  assign head = mem_r[rd_ptr_r];
  assign stat_pe = upm1 & head.pe & (count_r != 2'h0);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFF_DATA: rd_mux[8:0] = {1'b0, head.data[7:0]} & {1'b0, data_mask[7:0]};
      OFF_STAT_A:
      begin
        rd_mux[STA_RXC] = (count_r != 2'h0);
        rd_mux[STA_FE] = head.fe & (count_r != 2'h0);
        rd_mux[STA_DOR] = head.overrun_flag & (count_r != 2'h0);
        rd_mux[STA_PE] = stat_pe;
        rd_mux[STA_U2X] = u2x_r;
      end
      OFF_CTRL_B:
      begin
        rd_mux[7:0] = ctrl_b_r;
        rd_mux[CTB_NINTH_RX_BIT] = head.data[8] & (count_r != 2'h0);
      end
      OFF_CTRL_C: rd_mux[7:0] = ctrl_c_r;
      OFF_BAUD: rd_mux[BAUD_W-1:0] = baud_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (setup)
    begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_r <= ~mapped;
    end
  end

  // Error flag positions in status_reg_a are not writable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_b_r <= CTB_RESET;
      ctrl_c_r <= CTC_RESET;
      u2x_r <= 1'b0;
      baud_r <= BAUD_RESET;
    end
    else if (wr_acc)
    begin
      case (paddr)
        OFF_STAT_A: u2x_r <= pwdata[STA_U2X];
        OFF_CTRL_B: ctrl_b_r <= pwdata[7:0] & ~(8'h01 << CTB_NINTH_RX_BIT);
        OFF_CTRL_C: ctrl_c_r <= pwdata[7:0];
        OFF_BAUD: baud_r <= pwdata[BAUD_W-1:0];
        default: ;
      endcase
    end
  end

  // Pin synchronisers; the edge detector compares the second stage with its delayed copy xck_d_r
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      xck_s1_r <= 1'b0;
      xck_s2_r <= 1'b0;
      xck_d_r <= 1'b0;
    end
    else
    begin
      rx_s1_r <= serial_input_pin;
      rx_s2_r <= rx_s1_r;
      xck_s1_r <= external_transfer_clock_pin;
      xck_s2_r <= xck_s1_r;
      xck_d_r <= xck_s2_r;
    end
  end

  assign xck_rise = xck_s2_r & ~xck_d_r;

  // Oversampling tick: baud_r + 1 pclk cycles per sample
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      baud_cnt_r <= '0;
    else if (!receiver_enable_bit || baud_cnt_r == '0)
      baud_cnt_r <= baud_r;
    else
      baud_cnt_r <= baud_cnt_r - 1'b1;
  end

  assign tick = receiver_enable_bit & ~sync_mode & (baud_cnt_r == '0);
  assign maj = (v1_r & v2_r) | (v1_r & rx_s2_r) | (v2_r & rx_s2_r);
  assign bit_evt = sync_mode ? (receiver_enable_bit & xck_rise) : (tick & (smp_r == vote1 + 4'h2));
  assign bit_val = sync_mode ? rx_s2_r : maj;
  assign start_det = (state_r == ST_IDLE) & ~rx_s2_r & (sync_mode ? (receiver_enable_bit & xck_rise) : tick);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      smp_r <= 4'h0;
      v1_r <= 1'b1;
      v2_r <= 1'b1;
    end
    else if (start_det)
      smp_r <= 4'h2; // The detecting tick is sample 1, so the next tick is sample 2
    else if (tick && state_r != ST_IDLE)
    begin
      smp_r <= (smp_r == spb) ? 4'h0 : smp_r + 4'h1;
      if (smp_r == vote1)
        v1_r <= rx_s2_r;
      if (smp_r == vote1 + 4'h1)
        v2_r <= rx_s2_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= ST_IDLE;
      idx_r <= 4'h0;
      shift_r <= 10'h000;
    end
    else if (!receiver_enable_bit)
      state_r <= ST_IDLE;
    else
    begin
      case (state_r)
        ST_IDLE:
          if (start_det)
          begin
            state_r <= sync_mode ? ST_BITS : ST_START;
            idx_r <= 4'h0;
            shift_r <= 10'h000;
          end
        ST_START:
          if (bit_evt)
            state_r <= bit_val ? ST_IDLE : ST_BITS;
        ST_BITS:
          if (bit_evt)
          begin
            shift_r[idx_r] <= bit_val;
            idx_r <= idx_r + 4'h1;
            if (idx_r == total_bits - 4'h1)
              state_r <= ST_STOP;
          end
        ST_STOP:
          if (bit_evt)
            state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Frame assembled at the first stop bit
  always_comb
  begin
    frame_ent.data = shift_r[8:0] & data_mask;
    frame_ent.fe = ~bit_val;
    frame_ent.overrun_flag = 1'b0;
    frame_ent.pe = upm1 & (shift_r[nbits] != ((^frame_ent.data) ^ upm0));
  end

  assign full = (count_r == 2'h2);
  assign pop = rd_data_acc & (count_r != 2'h0);
  // A waiting frame enters first so order is kept
  assign push = receiver_enable_bit & ((pend_vld_r & (~full | pop)) | (~pend_vld_r & (state_r == ST_STOP) & bit_evt & (~full | pop)));

  always_comb
  begin
    push_ent = pend_vld_r ? pend_r : frame_ent;
    push_ent.overrun_flag = dor_pend_r;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_vld_r <= 1'b0;
      pend_r <= '0;
    end
    else if (!receiver_enable_bit)
      pend_vld_r <= 1'b0;
    else if (state_r == ST_STOP && bit_evt && (pend_vld_r || (full && !pop)))
    begin
      // With a frame already waiting the new one is lost, unless the waiting one enters the buffer in this cycle; then the new one waits
      if (!pend_vld_r)
      begin
        pend_vld_r <= 1'b1;
        pend_r <= frame_ent;
      end
      else if (push)
        pend_r <= frame_ent;
    end
    else if (push && pend_vld_r)
      pend_vld_r <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dor_pend_r <= 1'b0;
    else if (!receiver_enable_bit)
      dor_pend_r <= 1'b0;
    else if (start_det && full && pend_vld_r && !pop)
      dor_pend_r <= 1'b1;
    else if (push)
      dor_pend_r <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
    end
    else if (!receiver_enable_bit)
    begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= ~wr_ptr_r;
      if (pop)
        rd_ptr_r <= ~rd_ptr_r;
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end
    else if (push)
      mem_r[wr_ptr_r] <= push_ent;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_fall_enable;
    $fell(receiver_enable_bit);
  endsequence

  sequence s_buffer_empty;
    (count_r == 2'h0) && !rx_complete_irq;
  endsequence

  flush_on_off_a: assert property (s_fall_enable |=> s_buffer_empty)
    else $error("buffer not emptied on disable");
  irq_level_a: assert property (ctrl_b_r[CTB_RECEIVE_COMPLETE_IRQ_ENABLE] && count_r != 2'h0 |-> rx_complete_irq)
    else $error("interrupt missing while data buffered");
  pop_one_a: assert property (rd_data_acc && count_r == 2'h2 && !push |=> count_r == 2'h1)
    else $error("data read did not advance fifo");
  short_mask_a: assert property (setup && !pwrite && paddr == OFF_DATA && size_code == 3'h0
    |=> prdata_r[31:5] == 27'h0)
    else $error("unused data bits not zero");
  parity_off_a: assert property (!upm1 |-> !stat_pe)
    else $error("parity error visible with check off");
  frame_err_a: assert property (state_r == ST_STOP && bit_evt && count_r == 2'h0 && !pend_vld_r && receiver_enable_bit
    |=> count_r == 2'h1 && head.fe == !$past(bit_val))
    else $error("framing flag does not match stop bit");
  overrun_set_a: assert property (start_det && full && pend_vld_r && !pop && receiver_enable_bit |=> dor_pend_r)
    else $error("overrun not flagged");
  overrun_clr_a: assert property (push |=> !dor_pend_r)
    else $error("overrun not cleared on transfer");
  start_reject_a: assert property (state_r == ST_START && bit_evt && bit_val && receiver_enable_bit
    |=> state_r == ST_IDLE ##1 state_r == ST_IDLE || !rx_s2_r)
    else $error("noisy start bit accepted");
  sync_hold_a: assert property (sync_mode && receiver_enable_bit && state_r == ST_BITS && !xck_rise |=> $stable(idx_r))
    else $error("bit taken without transfer clock edge");

endmodule // uart_serial_receiver

//--- serial_tx_model.sv
`timescale 1ns/1ps
module serial_tx_model (
  input wire logic pclk,
  output logic rx_line,
  output logic clk_line
);
  // Clock stands low outside frames; line rests at the idle mark level
  initial
  begin
    rx_line = 1'b1;
    clk_line = 1'b0;
  end

  task automatic send(input logic [8:0] d, input int n, input logic pen, input logic podd,
                      input logic stop, input logic sync);
    logic b [0:11];
    int len;
    logic p;
    b[0] = 1'b0;
    p = podd;
    for (int i = 0; i < n; i++)
    begin
      b[i + 1] = d[i];
      p ^= d[i];
    end
    len = n + 1;
    if (pen)
    begin
      b[len] = p;
      len++;
    end
    b[len] = stop;
    len++;
    for (int i = 0; i < len; i++)
    begin
      rx_line <= b[i];
      if (sync)
      begin
        repeat (4) @(posedge pclk);
        clk_line <= 1'b1;
        repeat (4) @(posedge pclk);
        clk_line <= 1'b0;
      end
      else
        repeat (16) @(posedge pclk);
    end
    rx_line <= 1'b1;
    @(posedge pclk);
  endtask

  task automatic glitch(input int n);
    rx_line <= 1'b0;
    repeat (n) @(posedge pclk);
    rx_line <= 1'b1;
    repeat (200) @(posedge pclk);
  endtask
endmodule // serial_tx_model

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import uart_rx_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pin_override, rx_complete_irq, rx_pin, xck_pin, last_err;
  int n_mismatch = 0;
  int checks_done = 0;

  always #2 pclk = ~pclk;

  uart_serial_receiver dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_input_pin(rx_pin), .external_transfer_clock_pin(xck_pin),
    .pin_override(pin_override), .rx_complete_irq(rx_complete_irq));

  serial_tx_model tx (.pclk(pclk), .rx_line(rx_pin), .clk_line(xck_pin));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge pclk);
    end
    if (n == 50)
      check(32'h0, 32'h1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    apb(1'b1, a, d, v);
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    apb(1'b0, a, 32'h0, v);
    check(v, exp);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic t_reset;
    check({31'h0, pin_override}, 32'h0);
    rd(OFF_CTRL_B, 32'h00);
    rd(OFF_CTRL_C, 32'h06);
    rd(OFF_STAT_A, 32'h00);
    rd(8'h14, 32'h0);
    check({31'h0, last_err}, 32'h1);
  endtask

  task automatic t_basic;
    wr(OFF_CTRL_B, 32'h10);
    check({31'h0, pin_override}, 32'h1);
    tx.send(9'h0A5, 8, 1'b0, 1'b0, 1'b1, 1'b0);
    wt(4);
    rd(OFF_STAT_A, 32'h80);
    rd(OFF_DATA, 32'hA5);
    rd(OFF_STAT_A, 32'h00);
    wr(OFF_CTRL_C, 32'h00);
    tx.send(9'h1FF, 5, 1'b0, 1'b0, 1'b1, 1'b0);
    wt(4);
    rd(OFF_DATA, 32'h1F);
  endtask

  task automatic t_nine;
    wr(OFF_CTRL_B, 32'h14);
    wr(OFF_CTRL_C, 32'h06);
    tx.send(9'h155, 9, 1'b0, 1'b0, 1'b1, 1'b0);
    tx.send(9'h0AA, 9, 1'b0, 1'b0, 1'b1, 1'b0);
    wt(4);
    rd(OFF_CTRL_B, 32'h16);
    rd(OFF_DATA, 32'h55);
    rd(OFF_CTRL_B, 32'h14);
    rd(OFF_DATA, 32'hAA);
    wr(OFF_CTRL_B, 32'h10);
  endtask

  task automatic t_errors;
    wr(OFF_CTRL_C, 32'h26);
    tx.send(9'h003, 8, 1'b1, 1'b1, 1'b1, 1'b0);
    // A low stop bit must come last, else its tail reads as a new start
    tx.send(9'h081, 8, 1'b1, 1'b0, 1'b0, 1'b0);
    wt(4);
    check({31'h0, rx_complete_irq}, 32'h0);
    rd(OFF_STAT_A, 32'h84);
    wr(OFF_STAT_A, 32'h1C);
    rd(OFF_STAT_A, 32'h84);
    rd(OFF_DATA, 32'h03);
    rd(OFF_STAT_A, 32'h90);
    rd(OFF_DATA, 32'h81);
    wr(OFF_CTRL_C, 32'h36);
    tx.send(9'h003, 8, 1'b1, 1'b1, 1'b1, 1'b0);
    tx.send(9'h003, 8, 1'b1, 1'b0, 1'b1, 1'b0);
    wt(4);
    rd(OFF_STAT_A, 32'h80);
    rd(OFF_DATA, 32'h03);
    rd(OFF_STAT_A, 32'h84);
    wr(OFF_CTRL_C, 32'h06);
    rd(OFF_STAT_A, 32'h80);
    rd(OFF_DATA, 32'h03);
    rd(OFF_STAT_A, 32'h00);
  endtask

  task automatic t_overrun;
    for (int i = 0; i < 4; i++)
      tx.send(9'(17 + i), 8, 1'b0, 1'b0, 1'b1, 1'b0);
    wt(4);
    rd(OFF_STAT_A, 32'h80);
    rd(OFF_DATA, 32'h11);
    rd(OFF_STAT_A, 32'h80);
    rd(OFF_DATA, 32'h12);
    rd(OFF_STAT_A, 32'h88);
    rd(OFF_DATA, 32'h13);
    rd(OFF_STAT_A, 32'h00);
    tx.send(9'h015, 8, 1'b0, 1'b0, 1'b1, 1'b0);
    wt(4);
    rd(OFF_STAT_A, 32'h80);
    rd(OFF_DATA, 32'h15);
  endtask

  // A framing error frame, so a flag that leaked into the request would keep it up
  task automatic t_irq;
    wr(OFF_CTRL_B, 32'h90);
    tx.send(9'h05A, 8, 1'b0, 1'b0, 1'b0, 1'b0);
    wt(4);
    check({31'h0, rx_complete_irq}, 32'h1);
    rd(OFF_STAT_A, 32'h90);
    rd(OFF_DATA, 32'h5A);
    wt(2);
    check({31'h0, rx_complete_irq}, 32'h0);
    wr(OFF_CTRL_B, 32'h10);
  endtask

  task automatic t_disable;
    tx.send(9'h066, 8, 1'b0, 1'b0, 1'b1, 1'b0);
    fork
      tx.send(9'h077, 8, 1'b0, 1'b0, 1'b1, 1'b0);
      begin
        wt(60);
        wr(OFF_CTRL_B, 32'h00);
      end
    join
    check({31'h0, pin_override}, 32'h0);
    rd(OFF_STAT_A, 32'h00);
    wr(OFF_CTRL_B, 32'h10);
    wt(4);
    rd(OFF_STAT_A, 32'h00);
  endtask

  // Double speed with a tick every second clock keeps the 16-clock bit of the model
  task automatic t_double;
    wr(OFF_BAUD, 32'h1);
    wr(OFF_STAT_A, 32'h02);
    tx.glitch(6);
    rd(OFF_STAT_A, 32'h02);
    tx.send(9'h0C3, 8, 1'b0, 1'b0, 1'b1, 1'b0);
    wt(4);
    rd(OFF_STAT_A, 32'h82);
    rd(OFF_DATA, 32'hC3);
    wr(OFF_STAT_A, 32'h00);
    wr(OFF_BAUD, 32'h0);
  endtask

  task automatic t_noise_sync;
    tx.glitch(4);
    rd(OFF_STAT_A, 32'h00);
    tx.glitch(12);
    rd(OFF_STAT_A, 32'h80);
    rd(OFF_DATA, 32'hFF);
    wr(OFF_CTRL_C, 32'h46);
    tx.send(9'h03C, 8, 1'b0, 1'b0, 1'b1, 1'b1);
    wt(4);
    rd(OFF_STAT_A, 32'h80);
    rd(OFF_DATA, 32'h3C);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_basic;
    t_nine;
    t_errors;
    t_overrun;
    t_irq;
    t_disable;
    t_double;
    t_noise_sync;
    print_verdict;
  end

  // About seventeen times the length of all frames sent
  initial
  begin
    #200000;
    n_mismatch++;
    print_verdict;
  end
endmodule // tb_top
